// ### logic/fsp_pipe_ctrl.v
/*
 * four-stage pipeline control: fetch, decode, read, execute, plus dma grant.
 * assumes instruction words arrive pre-decoded per fsp_map.vh, fetch data is
 * valid in the cycle it is requested, and memories report busy levels.
 */
`include "fsp_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fsp_pipe_ctrl #(
	parameter W = 32
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	input  wire [W-1:0] fetch_word,
	input  wire         fetch_busy,
	input  wire         read_busy,
	input  wire         exec_busy,
	input  wire         dma_req,
	input  wire         irq,
	input  wire [W-1:0] irq_vector,
	input  wire [W-1:0] target_addr,
	input  wire [W-1:0] exec_data,
	output wire         fetch_req,
	output reg  [W-1:0] program_counter,
	output wire         decode_ag_en,
	output wire [2:0]   decode_grp_upd,
	output wire         read_mem_en,
	output wire         exec_en,
	output wire         exec_reg_wr,
	output wire         exec_mem_wr,
	output wire         dma_grant,
	output wire         flushing,
	output reg  [W-1:0] loop_begin_addr_q,
	output reg  [W-1:0] loop_end_addr_q,
	output reg  [W-1:0] loop_count_q,
	output reg          loop_active
);

	localparam ST_RUN   = 3'h1;
	localparam ST_DUMMY = 3'h2;
	localparam ST_IDLE  = 3'h4;

	// ------------------------------------------------------------
	// field decode helpers
	// ------------------------------------------------------------
	function [2:0] f_flow;
		input [W-1:0] iw;
		begin
			f_flow = iw[`FSP_F_FLOW_HI:`FSP_F_FLOW_LO];
		end
	endfunction

	function [2:0] f_gwr;
		input [W-1:0] iw;
		begin
			f_gwr = iw[`FSP_F_GWR_HI:`FSP_F_GWR_LO];
		end
	endfunction

	function [2:0] f_grd;
		input [W-1:0] iw;
		begin
			f_grd = iw[`FSP_F_GRD_HI:`FSP_F_GRD_LO];
		end
	endfunction

	// ------------------------------------------------------------
	// stage registers
	// ------------------------------------------------------------
	reg  [W-1:0] d_iw;
	reg          d_v;
	reg  [W-1:0] r_iw;
	reg          r_v;
	reg  [W-1:0] e_iw;
	reg          e_v;
	reg  [2:0]   state;
	reg  [1:0]   dslots;
	reg  [W-1:0] pend_target;
	reg          pend_jump;
	reg  [1:0]   raw_cnt;
	reg  [2:0]   raw_grp;

	wire [1:0]   e_lsel;
	wire         loop_step;
	wire [W-1:0] lb;
	wire [W-1:0] le;
	wire [W-1:0] lc;

	// ------------------------------------------------------------
	// interlocks
	// ------------------------------------------------------------
	wire [2:0] d_guse = d_iw[`FSP_F_GUSE_HI:`FSP_F_GUSE_LO];
	// a write pending in read or execute blocks use of that group
	wire [2:0] wr_busy = (r_v ? f_gwr(r_iw) : `FSP_GRP_NONE)
		| (e_v ? f_gwr(e_iw) : `FSP_GRP_NONE);
	// operand reads of the instruction now in read stage take place at its execute start
	wire [2:0] rd_busy = (r_v ? (f_grd(r_iw) & `FSP_GRD_DELAY) : `FSP_GRP_NONE);
	wire raw_stall = (raw_cnt != 2'h0) && ((raw_grp & d_guse) != `FSP_GRP_NONE);
	wire ilock = d_v && (((wr_busy | rd_busy) & d_guse) != `FSP_GRP_NONE || raw_stall);

	// ------------------------------------------------------------
	// priority chain: each stage advances only if the one above accepts
	// ------------------------------------------------------------
	wire e_adv = !exec_busy;
	wire r_adv = e_adv && !read_busy;
	wire d_adv = r_adv && !ilock;
	wire e_flow_flush = e_v && e_adv && (f_flow(e_iw) == `FSP_FLOW_BRANCH
		|| f_flow(e_iw) == `FSP_FLOW_SLOOP || f_flow(e_iw) == `FSP_FLOW_BLOOP
		|| f_flow(e_iw) == `FSP_FLOW_IDLE);
	wire flush = e_flow_flush || (irq && e_adv);
	wire f_take = d_adv && state == ST_RUN && !fetch_busy && !flush && dslots == 2'h0
		? 1'b1 : (d_adv && state == ST_RUN && !fetch_busy && !flush);
	wire d_is_flow = d_v && (f_flow(d_iw) == `FSP_FLOW_BRANCH || f_flow(d_iw) == `FSP_FLOW_SLOOP
		|| f_flow(d_iw) == `FSP_FLOW_BLOOP || f_flow(d_iw) == `FSP_FLOW_IDLE);

	// fetch drives memory while running with no flush, or during the dummy cycle; a stalled decode refetches
	assign fetch_req = (state == ST_RUN && !flush) || state == ST_DUMMY;
	assign decode_ag_en = d_v && d_adv;
	assign decode_grp_upd = decode_ag_en ? f_gwr(d_iw) : `FSP_GRP_NONE;
	assign read_mem_en = r_v && r_adv && r_iw[`FSP_F_MEMRD];
	assign exec_en = e_v && e_adv;
	assign exec_reg_wr = exec_en && e_iw[`FSP_F_REGWR];
	assign exec_mem_wr = exec_en && e_iw[`FSP_F_MEMWR];
	// dma gets shared memory only when fetch leaves it free; own buses otherwise
	assign dma_grant = dma_req && !fetch_req;
	assign flushing = state != ST_RUN || flush;
	assign e_lsel = exec_en ? e_iw[`FSP_F_LDLOOP_HI:`FSP_F_LDLOOP_LO] : `FSP_LSEL_NONE;
	assign loop_step = loop_active && exec_en && program_counter == le;

	// ------------------------------------------------------------
	// loop registers
	// ------------------------------------------------------------
	fsp_loop_regs #(
		.W (W)
	) u_loop (
		.clk                  (clk),
		.rst                  (rst),
		.ce                   (ce),
		.load_sel             (e_lsel),
		.load_data            (exec_data),
		.loop_step            (loop_step),
		.loop_begin_addr      (lb),
		.loop_end_addr        (le),
		.loop_iteration_count (lc)
	);

	// ------------------------------------------------------------
	// pipeline and fetch control
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			program_counter <= `FSP_PC_RESET;
			d_iw        <= `FSP_ZERO32;
			d_v         <= 1'b0;
			r_iw        <= `FSP_ZERO32;
			r_v         <= 1'b0;
			e_iw        <= `FSP_ZERO32;
			e_v         <= 1'b0;
			state       <= ST_RUN;
			dslots      <= 2'h0;
			pend_target <= `FSP_ZERO32;
			pend_jump   <= 1'b0;
			raw_cnt     <= 2'h0;
			raw_grp     <= `FSP_GRP_NONE;
			loop_active <= 1'b0;
			loop_begin_addr_q <= `FSP_ZERO32;
			loop_end_addr_q   <= `FSP_ZERO32;
			loop_count_q      <= `FSP_ZERO32;
		end else if (ce) begin
			loop_begin_addr_q <= lb;
			loop_end_addr_q   <= le;
			loop_count_q      <= lc;
			// execute stage
			if (e_adv) begin
				e_iw <= r_iw;
				e_v  <= r_adv && r_v && !flush;
			end
			// read stage
			if (r_adv) begin
				r_iw <= d_iw;
				r_v  <= d_adv && d_v && !flush && !d_is_flow ? 1'b1
					: (d_adv && d_v && !flush);
			end
			// group register load then use: hold decode across the write's execute
			if (decode_ag_en && f_gwr(d_iw) != `FSP_GRP_NONE) begin
				raw_cnt <= `FSP_RAW_HOLD;
				raw_grp <= f_gwr(d_iw);
			end else if (raw_cnt != 2'h0 && e_adv) begin
				raw_cnt <= raw_cnt - 2'h1;
			end
			// decode stage
			if (flush) begin
				d_v <= 1'b0;
			end else if (d_adv) begin
				d_iw <= fetch_word;
				d_v  <= f_take;
			end
			// delayed branch: let three more words through, then jump
			if (decode_ag_en && f_flow(d_iw) == `FSP_FLOW_DELAYED) begin
				dslots      <= `FSP_DSLOTS;
				pend_target <= target_addr;
			end else if (dslots != 2'h0 && f_take) begin
				dslots <= dslots - 2'h1;
			end
			// program counter and flush sequencing
			case (state)
				ST_RUN: begin
					if (flush) begin
						state       <= ST_DUMMY;
						pend_jump   <= 1'b1;
						pend_target <= irq ? irq_vector : target_addr;
						if (f_flow(e_iw) == `FSP_FLOW_SLOOP || f_flow(e_iw) == `FSP_FLOW_BLOOP) begin
							loop_active <= 1'b1;
						end
						if (e_v && f_flow(e_iw) == `FSP_FLOW_IDLE && !irq) begin
							state <= ST_IDLE;
						end
					end else if (f_take) begin
						if (dslots == `FSP_DSLOT_LAST) begin
							program_counter <= pend_target;
							dslots          <= 2'h0;
						end else if (loop_active && program_counter == le && lc != `FSP_ZERO32) begin
							program_counter <= lb;
						end else begin
							program_counter <= program_counter + `FSP_ONE32;
						end
						if (loop_active && program_counter == le && lc == `FSP_ZERO32) begin
							loop_active <= 1'b0;
						end
					end
				end
				ST_DUMMY: begin
					// dummy fetch done; new fetch starts from the target
					program_counter <= pend_target;
					pend_jump       <= 1'b0;
					state           <= ST_RUN;
				end
				ST_IDLE: begin
					if (irq) begin
						pend_target <= irq_vector;
						state       <= ST_DUMMY;
					end
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### logic/fsp_map.vh
/*
 * constants for the four-stage pipeline control: instruction field layout,
 * flow kinds, interlock group bits and the register selectors of the loop block.
 * assumes it is included by bare name from the logic files.
 */
`ifndef FSP_MAP_VH
`define FSP_MAP_VH

// ------------------------------------------------------------
// pre-decoded instruction word fields
// ------------------------------------------------------------
`define FSP_IW_W         32
`define FSP_F_FLOW_LO    0
`define FSP_F_FLOW_HI    2
`define FSP_F_MEMRD      3
`define FSP_F_MEMWR      4
`define FSP_F_GWR_LO     5
`define FSP_F_GWR_HI     7
`define FSP_F_GUSE_LO    8
`define FSP_F_GUSE_HI    10
`define FSP_F_GRD_LO     11
`define FSP_F_GRD_HI     13
`define FSP_F_LDLOOP_LO  14
`define FSP_F_LDLOOP_HI  15
`define FSP_F_REGWR      16

// ------------------------------------------------------------
// flow kinds
// ------------------------------------------------------------
`define FSP_FLOW_W       3
`define FSP_FLOW_NONE    3'h0
`define FSP_FLOW_BRANCH  3'h1
`define FSP_FLOW_DELAYED 3'h2
`define FSP_FLOW_SLOOP   3'h3
`define FSP_FLOW_BLOOP   3'h4
`define FSP_FLOW_IDLE    3'h5

// ------------------------------------------------------------
// interlock groups: bit 0 pointers/index/size, bit 1 page, bit 2 stack
// ------------------------------------------------------------
`define FSP_GRP_W        3
`define FSP_GRP_NONE     3'h0
// groups whose operand reads delay the next decode (pointers/index/size and stack; page exempt)
`define FSP_GRD_DELAY    3'h5

// ------------------------------------------------------------
// direct loop register loads
// ------------------------------------------------------------
`define FSP_LSEL_W       2
`define FSP_LSEL_NONE    2'h0
`define FSP_LSEL_BEGIN   2'h1
`define FSP_LSEL_END     2'h2
`define FSP_LSEL_COUNT   2'h3

// ------------------------------------------------------------
// misc
// ------------------------------------------------------------
`define FSP_PC_RESET     32'h00000000
`define FSP_ZERO32       32'h00000000
`define FSP_ONE32        32'h00000001
`define FSP_DSLOTS       2'h3
// slot count at which the jump is taken: the first slot is fetched while the branch decodes
`define FSP_DSLOT_LAST   2'h2
`define FSP_RAW_HOLD     2'h2

`endif

// ### logic/fsp_loop_regs.v
/*
 * loop begin/end/count registers, usable as general registers.
 * assumes load strobes come from the execute stage and that the looping
 * logic decrements the count once per pass while a loop mode is active.
 */
`include "fsp_map.vh"
`timescale 1ns/1ps
`default_nettype none

module fsp_loop_regs #(
	parameter W = 32
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         ce,
	input  wire [1:0]   load_sel,
	input  wire [W-1:0] load_data,
	input  wire         loop_step,
	output reg  [W-1:0] loop_begin_addr,
	output reg  [W-1:0] loop_end_addr,
	output reg  [W-1:0] loop_iteration_count
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			loop_begin_addr      <= `FSP_ZERO32;
			loop_end_addr        <= `FSP_ZERO32;
			loop_iteration_count <= `FSP_ZERO32;
		end else if (ce) begin
			if (load_sel == `FSP_LSEL_BEGIN) begin
				loop_begin_addr <= load_data;
			end
			if (load_sel == `FSP_LSEL_END) begin
				loop_end_addr <= load_data;
			end
			// direct load beats the looping decrement
			if (load_sel == `FSP_LSEL_COUNT) begin
				loop_iteration_count <= load_data;
			end else if (loop_step) begin
				loop_iteration_count <= loop_iteration_count - `FSP_ONE32;
			end
		end
	end

endmodule

`default_nettype wire

// ### dv/fsp_pipe_sva.sv
/*
 * port checker for the four-stage pipeline control.
 * assumes the single clk domain with async active-high rst; bound below.
 */
`timescale 1ns/1ps
`default_nettype none

module fsp_pipe_sva #(
	parameter W = 32
) (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic         ce,
	input wire logic         read_busy,
	input wire logic         exec_busy,
	input wire logic         dma_req,
	input wire logic         fetch_req,
	input wire logic [W-1:0] program_counter,
	input wire logic         read_mem_en,
	input wire logic         exec_en,
	input wire logic         exec_reg_wr,
	input wire logic         exec_mem_wr,
	input wire logic         dma_grant
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_dma_last_grant: assert property (dma_grant == (dma_req && !fetch_req))
		else $error("dma grant not below fetch");
	a_exec_busy_hold: assert property (exec_busy && ce |=> $stable(program_counter))
		else $error("fetch moved while execute busy");
	a_read_busy_hold: assert property (read_busy && ce |=> $stable(program_counter))
		else $error("fetch moved while read busy");
	a_freeze_holds_pc: assert property (!ce |=> $stable(program_counter))
		else $error("pc moved while frozen");
	a_reset_flush_empty: assert property ($fell(rst) |-> program_counter == '0 && !exec_en && !read_mem_en)
		else $error("pipeline not empty after reset");
	a_mem_wr_in_exec: assert property (exec_mem_wr |-> exec_en)
		else $error("memory write without execute");
	a_reg_wr_in_exec: assert property (exec_reg_wr |-> exec_en)
		else $error("register write without execute");
	a_read_then_exec: assert property (read_mem_en && ce && !read_busy && !exec_busy |=> exec_en)
		else $error("read stage did not pass to execute");
endmodule

bind fsp_pipe_ctrl fsp_pipe_sva #(.W(W)) sva_u (.clk(clk), .rst(rst), .ce(ce), .read_busy(read_busy),
	.exec_busy(exec_busy), .dma_req(dma_req), .fetch_req(fetch_req), .program_counter(program_counter),
	.read_mem_en(read_mem_en), .exec_en(exec_en), .exec_reg_wr(exec_reg_wr), .exec_mem_wr(exec_mem_wr),
	.dma_grant(dma_grant));

`default_nettype wire

// ### dv/fsp_prog_mem.sv
/*
 * program memory model answering the fetch stage.
 * assumes the bench loads mem directly; slow makes every fetch wait.
 */
`timescale 1ns/1ps
`default_nettype none

module fsp_prog_mem (
	input  wire logic        clk,
	input  wire logic        fetch_req,
	input  wire logic        slow,
	input  wire logic [31:0] program_counter,
	output wire logic [31:0] fetch_word,
	output wire logic        fetch_busy
);
	// ----------------------------------------
	// storage and answer
	// ----------------------------------------
	logic [31:0] mem [0:63];
	logic [31:0] junk = 32'h0;

	// outside a fetch the bus shows a changing pattern, not a stale word
	always @(posedge clk)
		junk <= ~junk;
	assign fetch_busy = slow;
	// every request is served while slow is low, refetches of a stalled word included
	assign fetch_word = (fetch_req && !slow) ? mem[program_counter[5:0]] : junk;
endmodule

`default_nettype wire

// ### dv/test_four_stage_pipeline_control.sv
/*
 * self-checking bench for the four-stage pipeline control.
 * assumes fsp_prog_mem as program memory and the bound port checker.
 */
`timescale 1ns/1ps
`default_nettype none

module test_four_stage_pipeline_control;
	logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
	logic        read_busy = 1'b0, exec_busy = 1'b0, dma_req = 1'b0, irq = 1'b0;
	logic [31:0] target_addr = 32'h20, exec_data = 32'h5;
	wire  [31:0] fetch_word, program_counter, lc;
	wire         fetch_busy, fetch_req, ex_en, flushing;
	int          mismatches = 0, n_checks = 0, cyc = 0, n, k, f;
	logic [31:0] grp_tbl [0:20] = '{32'h20, 32'h100, 32'hE, 32'h40, 32'h200, 32'hE, 32'h20, 32'h200, 32'hC,
		32'h800, 32'h100, 32'hD, 32'h1000, 32'h200, 32'hC, 32'h2000, 32'h400, 32'hD, 32'h18, 32'h10000, 32'hC};
	logic [31:0] flow_w [0:4] = '{32'h1, 32'h3, 32'h4, 32'h5, 32'hC000};

	fsp_pipe_ctrl #(.W(32)) dut_u (.clk(clk), .rst(rst), .ce(ce), .fetch_word(fetch_word),
		.fetch_busy(fetch_busy), .read_busy(read_busy), .exec_busy(exec_busy), .dma_req(dma_req), .irq(irq),
		.irq_vector(32'h0), .target_addr(target_addr), .exec_data(exec_data), .fetch_req(fetch_req),
		.program_counter(program_counter), .decode_ag_en(), .decode_grp_upd(), .read_mem_en(),
		.exec_en(ex_en), .exec_reg_wr(), .exec_mem_wr(), .dma_grant(), .flushing(flushing),
		.loop_begin_addr_q(), .loop_end_addr_q(), .loop_count_q(lc), .loop_active());
	fsp_prog_mem pm_u (.clk(clk), .fetch_req(fetch_req), .slow(slow), .program_counter(program_counter),
		.fetch_word(fetch_word), .fetch_busy(fetch_busy));

	// ----------------------------------------
	// clock, watchdog, helpers
	// ----------------------------------------
	always #2 clk = ~clk;

	// whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// called at a falling edge; words 0..2 of the program, rest no-ops
	task automatic restart(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
		rst = 1'b1;
		for (int i = 0; i < 64; i++)
			pm_u.mem[i] = 32'h0;
		pm_u.mem[0] = w0;
		pm_u.mem[1] = w1;
		pm_u.mem[2] = w2;
		repeat (2) @(negedge clk);
		rst = 1'b0;
	endtask

	task automatic run_to(input logic [31:0] a);
		n = 0;
		k = 0;
		f = 0;
		while (program_counter !== a && n < 60) begin
			@(negedge clk);
			n++;
			k += (ex_en === 1'b1);
			f += (fetch_req === 1'b1);
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_stream();
		restart(32'h0, 32'h0, 32'h0);
		chk("pc after reset", 32'h0, program_counter);
		run_to(32'hC);
		chk("cycles to pc 12", 32'hC, n);
		chk("instructions executed", 32'hA, k);
		$display("test stream done");
	endtask

	task automatic t_hold();
		restart(32'h0, 32'h0, 32'h0);
		dma_req = 1'b1;
		n = 0;
		while (program_counter !== 32'h14 && n < 60) begin
			exec_busy = n >= 3 && n < 5;
			read_busy = n >= 5 && n < 7;
			slow = n >= 7 && n < 9;
			ce = !(n >= 9 && n < 11);
			@(negedge clk);
			n++;
		end
		dma_req = 1'b0;
		chk("cycles with holds", 32'h1C, n);
		$display("test hold done");
	endtask

	task automatic t_groups();
		for (int i = 0; i < 21; i += 3) begin
			restart(grp_tbl[i], grp_tbl[i+1], 32'h0);
			run_to(32'hC);
			chk("cycles with interlock", grp_tbl[i+2], n);
			chk("refetch cycles", n, f);
		end
		$display("test groups done");
	endtask

	task automatic t_flow();
		for (int i = 0; i < 5; i++) begin
			restart(32'h0, 32'h0, flow_w[i]);
			k = 0;
			repeat (10) begin
				@(negedge clk);
				k += (flushing === 1'b1);
			end
			chk("flush seen", i < 4, k != 0);
		end
		// no loop is active at the direct load, so no flushing branch has to follow it
		chk("direct count load", 32'h5, lc);
		restart(32'h0, 32'h0, 32'h1);
		run_to(32'h20);
		chk("branch target reached", 32'h20, program_counter);
		$display("test flow done");
	endtask

	task automatic t_delayed();
		restart(32'h0, 32'h0, 32'h2);
		run_to(32'h2);
		for (int i = 0; i < 4; i++) begin
			@(negedge clk);
			chk("pc after delayed branch", (i < 3) ? 32'h3 + i : 32'h20, program_counter);
		end
		$display("test delayed done");
	endtask

	initial begin
		repeat (8) @(negedge clk);
		t_stream();
		t_hold();
		t_groups();
		t_flow();
		t_delayed();
		report_and_stop();
	end
endmodule

`default_nettype wire
